// ==== logic/aid_pkg.sv ====
package aid_pkg;

  // Direct-space addresses of the core's own registers
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_B = 8'hF0;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_SP = 8'h81;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;

  // Status word bit positions
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Opcode rows (high nibble) and low-nibble operand forms
  localparam logic [3:0] ROW_INC = 4'h0;
  localparam logic [3:0] ROW_DEC = 4'h1;
  localparam logic [3:0] ROW_ADD = 4'h2;
  localparam logic [3:0] ROW_SUM_WITH_CARRY_OP = 4'h3;
  localparam logic [3:0] ROW_DIFFERENCE_BORROW_OP = 4'h9;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [3:0] LO_AJMP = 4'h1;

  // Whole opcodes handled individually
  localparam logic [7:0] OPC_MUL = 8'hA4;
  localparam logic [7:0] OPC_DIV = 8'h84;
  localparam logic [7:0] OPC_DA = 8'hD4;
  localparam logic [7:0] OPC_INC_DP = 8'hA3;
  localparam logic [7:0] OPC_CLR_C = 8'hC3;
  localparam logic [7:0] OPC_SET_C = 8'hD3;
  localparam logic [7:0] OPC_INV_C = 8'hB3;
  localparam logic [7:0] OPC_RLC = 8'h33;
  localparam logic [7:0] OPC_RRC = 8'h13;
  localparam logic [7:0] OPC_CLR_BIT = 8'hC2;
  localparam logic [7:0] OPC_SET_BIT = 8'hD2;
  localparam logic [7:0] OPC_INV_BIT = 8'hB2;
  localparam logic [7:0] OPC_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0] OPC_MOV_A_DIR = 8'hE5;
  localparam logic [7:0] OPC_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OPC_MOV_DIR_A = 8'hF5;
  localparam logic [7:0] OPC_MOV_DP = 8'h90;
  localparam logic [7:0] OPC_TBL_DP = 8'h93;
  localparam logic [7:0] OPC_TBL_PC = 8'h83;
  localparam logic [7:0] OPC_XRD_DP = 8'hE0;
  localparam logic [7:0] OPC_XRD_R0 = 8'hE2;
  localparam logic [7:0] OPC_XRD_R1 = 8'hE3;
  localparam logic [7:0] OPC_XWR_DP = 8'hF0;
  localparam logic [7:0] OPC_XWR_R0 = 8'hF2;
  localparam logic [7:0] OPC_XWR_R1 = 8'hF3;
  localparam logic [7:0] OPC_PUSH = 8'hC0;
  localparam logic [7:0] OPC_POP = 8'hD0;

  // Cycle counts of the multi-cycle instructions
  localparam logic [2:0] CYC_MULDIV = 3'h5;
  localparam logic [2:0] CYC_INC_DP = 3'h3;
  localparam logic [2:0] CYC_TABLE = 3'h3;
  localparam logic [2:0] CYC_AUX = 3'h2;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUM_WITH_CARRY_OP, ALU_DIFFERENCE_BORROW_OP, ALU_INC, ALU_DEC, ALU_MUL, ALU_DIV, ALU_DA, ALU_NONE
  } aid_alu_op_t;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_BYTES = 3'b010,
    ST_WAIT = 3'b100
  } aid_state_t;

  // Instruction length in bytes, for every opcode of the set
  function automatic logic [2:0] aid_len(input logic [7:0] op);
    if (op[3:0] == LO_AJMP) begin
      return 3'h2;
    end
    if (op[7:4] == 4'hB && op[3:2] != 2'h0) begin
      return 3'h3;
    end
    if (op[3] && (op[7:4] == 4'h7 || op[7:4] == 4'h8 || op[7:4] == 4'hA
        || op[7:4] == 4'hD)) begin
      return 3'h2;
    end
    case (op)
      8'h02, 8'h10, 8'h12, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85,
      8'h90, 8'hD5: return 3'h3;
      8'h05, 8'h15, 8'h24, 8'h25, 8'h34, 8'h35, 8'h40, 8'h42, 8'h44, 8'h45,
      8'h50, 8'h52, 8'h54, 8'h55, 8'h60, 8'h62, 8'h64, 8'h65, 8'h70, 8'h72,
      8'h74, 8'h76, 8'h77, 8'h80, 8'h82, 8'h86, 8'h87, 8'h92, 8'h94, 8'h95,
      8'hA0, 8'hA2, 8'hA6, 8'hA7, 8'hB0, 8'hB2, 8'hC0, 8'hC2, 8'hC5, 8'hD0,
      8'hD2, 8'hE5, 8'hF5: return 3'h2;
      default: return 3'h1;
    endcase
  endfunction

  // Machine cycles an instruction occupies
  function automatic logic [2:0] aid_cycles(input logic [7:0] op);
    case (op)
      OPC_MUL, OPC_DIV: return CYC_MULDIV;
      OPC_INC_DP: return CYC_INC_DP;
      OPC_TBL_DP, OPC_TBL_PC: return CYC_TABLE;
      OPC_XRD_DP, OPC_XRD_R0, OPC_XRD_R1,
      OPC_XWR_DP, OPC_XWR_R0, OPC_XWR_R1: return CYC_AUX;
      default: return aid_len(op);
    endcase
  endfunction

endpackage

// ==== logic/aid_alu.sv ====
`timescale 1ns/1ps
module aid_alu
  import aid_pkg::*;
(
  // Operation select
  input wire aid_alu_op_t aluOp,
  // Operands and incoming flags
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic cyIn,
  input wire logic acIn,
  // Results
  output logic [7:0] res,
  output logic [7:0] resHi,
  output logic cyOut,
  output logic acOut,
  output logic ovOut
);

  logic [8:0] wide;
  logic [4:0] nib;
  logic [15:0] prod;
  logic cin;

  // Arithmetic core; carry and aux carry it does not own pass through unchanged, overflow defaults to zero
  always_comb begin
    wide = 9'h000;
    nib = 5'h00;
    prod = 16'h0000;
    cin = (aluOp == ALU_SUM_WITH_CARRY_OP || aluOp == ALU_DIFFERENCE_BORROW_OP) ? cyIn : 1'b0;
    res = opA;
    resHi = opB;
    cyOut = cyIn;
    acOut = acIn;
    ovOut = 1'b0;
    case (aluOp)
      ALU_ADD, ALU_SUM_WITH_CARRY_OP: begin
        wide = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
        nib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
        res = wide[7:0];
        cyOut = wide[8];
        acOut = nib[4];
        // Signed overflow: like signs in, other sign out
        ovOut = (opA[7] == opB[7]) && (wide[7] != opA[7]);
      end
      ALU_DIFFERENCE_BORROW_OP: begin
        wide = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
        nib = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
        res = wide[7:0];
        cyOut = wide[8];
        acOut = nib[4];
        ovOut = (opA[7] != opB[7]) && (wide[7] != opA[7]);
      end
      ALU_INC: res = opA + 8'h01;
      ALU_DEC: res = opA - 8'h01;
      ALU_MUL: begin
        prod = {8'h00, opA} * {8'h00, opB};
        res = prod[7:0];
        resHi = prod[15:8];
        cyOut = 1'b0;
        ovOut = |prod[15:8];
      end
      ALU_DIV: begin
        cyOut = 1'b0;
        // Divide by zero leaves both operands and raises overflow
        if (opB == 8'h00) begin
          ovOut = 1'b1;
        end else begin
          res = opA / opB;
          resHi = opA % opB;
        end
      end
      ALU_DA: begin
        wide = {1'b0, opA};
        if (opA[3:0] > 4'h9 || acIn) begin
          wide = wide + 9'h006;
        end
        if (wide[7:4] > 4'h9 || cyIn || wide[8]) begin
          wide = wide + 9'h060;
          cyOut = 1'b1;
        end
        res = wide[7:0];
      end
      default: res = opA;
    endcase
  end

endmodule

// ==== logic/aid_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Opcodes and operand byte layout match the standard 8-bit instruction set.
// - Instructions are one, two or three bytes long, decoded per opcode.
// - Two-operand non-transfer instructions read their destination as a source.
// - Register mode reaches bank registers in four banks, A, B, carry, pair, pointer.
// - Direct mode reaches low RAM, special registers and both bit areas.
// - Indirect RAM addresses come from pointer register 0/1 or stack pointer.
// - Auxiliary RAM uses 8-bit pointer register or 16-bit data pointer address.
// - Immediate constants of 8 or 16 bits come from instruction bytes.
// - Table reads use accumulator plus data pointer or program counter.
// - Only register, direct and indirect modes serve as destinations.
// - Arithmetic, multiply, divide, adjust and carry ops update flags as listed.
// - Byte or bit writes to the status word change flags directly.
// - Add opcodes 2*, 25, 26/27, 24 take 1, 2, 1, 2 cycles.
// - Add-with-carry opcodes 3*, 35, 36/37, 34 add carry, same cycle counts.
// - Subtract-with-borrow opcodes 9*, 95, 96/97, 94 subtract carry as borrow.
module aid_core
  import aid_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Program memory, combinational read
  output logic [15:0] codeAddr,
  input wire logic [7:0] codeData,
  // Auxiliary RAM, combinational read
  output logic [15:0] auxAddr,
  output logic [7:0] auxWrData,
  output logic auxWrEn,
  output logic auxRdEn,
  input wire logic [7:0] auxRdData,
  // Observation
  output logic [7:0] accOut,
  output logic [7:0] statusOut,
  output logic [15:0] pcOut,
  output logic instrDone
);

  aid_state_t state, next_state;
  logic [2:0] step, next_step;
  logic [15:0] pc, next_pc;
  logic [7:0] opReg, next_opReg;
  logic [7:0] byte1, next_byte1;
  logic [7:0] acc, next_acc;
  logic [7:0] b, next_b;
  logic [7:0] program_status_word, next_psw;
  logic [7:0] sp, next_sp;
  logic [7:0] dpl, next_dpl;
  logic [7:0] dph, next_dph;
  logic [7:0] iram [0:127];

  logic [7:0] op, cur1, riVal, rdAddr, rdByte, sfrByte, operand, pswLive;
  logic [7:0] wrAddr, wrData, bitByte, spInc;
  logic [3:0] hi, lo;
  logic [2:0] len, cyc;
  logic [6:0] regAddr, riAddr;
  logic [1:0] bank;
  logic last, wrEn, bitVal;
  aid_alu_op_t aluOp;
  logic [7:0] aluA, aluB, aluRes, aluHi;
  logic aluCy, aluAc, aluOv;

  assign op = (state == ST_FETCH) ? codeData : opReg;
  assign cur1 = (step == 3'h1) ? codeData : byte1;
  assign hi = op[7:4];
  assign lo = op[3:0];
  assign len = aid_len(op);
  assign cyc = aid_cycles(op);
  assign last = (step == cyc - 3'h1);
  assign instrDone = last;

  // Parity is live from the accumulator, never stored
  assign pswLive = {program_status_word[7:1], ^acc};
  assign bank = program_status_word[PSW_RS_HI:PSW_RS_LO];
  assign regAddr = {2'b00, bank, lo[2:0]};
  assign riAddr = {2'b00, bank, 2'b00, op[0]};
  assign riVal = iram[riAddr];
  assign spInc = sp + 8'h01;

  // bit address to its holding byte in RAM or special space
  assign bitByte = cur1[7] ? {cur1[7:3], 3'b000} : BIT_RAM_BASE + {4'h0, cur1[6:3]};
  assign bitVal = rdByte[cur1[2:0]];

  // Read port address over the direct space
  always_comb begin
    rdAddr = cur1;
    if (op == OPC_POP) begin
      rdAddr = sp;
    end else if (op == OPC_CLR_BIT || op == OPC_SET_BIT || op == OPC_INV_BIT) begin
      rdAddr = bitByte;
    end else if (hi != 4'hD && hi != 4'hC && lo[3]) begin
      rdAddr = {1'b0, regAddr};
    end else if (lo == 4'h6 || lo == 4'h7) begin
      // indirect through pointer register, low RAM only
      rdAddr = {1'b0, riVal[6:0]};
    end
  end

  // Special register read mux; unmapped ones read zero
  always_comb begin
    case (rdAddr)
      ADDR_ACC: sfrByte = acc;
      ADDR_B: sfrByte = b;
      ADDR_PSW: sfrByte = pswLive;
      ADDR_SP: sfrByte = sp;
      ADDR_DPL: sfrByte = dpl;
      ADDR_DPH: sfrByte = dph;
      default: sfrByte = BYTE_ZERO;
    endcase
  end
  assign rdByte = rdAddr[7] ? sfrByte : iram[rdAddr[6:0]];

  // immediate form takes the in-code byte
  assign operand = (lo == LO_IMM) ? cur1 : rdByte;

  // ALU select and operands
  always_comb begin
    aluOp = ALU_NONE;
    aluA = acc;
    aluB = operand;
    if (lo >= LO_IMM) begin
      case (hi)
        ROW_ADD: aluOp = ALU_ADD;
        ROW_SUM_WITH_CARRY_OP: aluOp = ALU_SUM_WITH_CARRY_OP;
        ROW_DIFFERENCE_BORROW_OP: aluOp = ALU_DIFFERENCE_BORROW_OP;
        ROW_INC: aluOp = ALU_INC;
        ROW_DEC: aluOp = ALU_DEC;
        default: aluOp = ALU_NONE;
      endcase
    end
    if (hi == ROW_INC || hi == ROW_DEC) begin
      aluA = (lo == LO_IMM) ? acc : rdByte;
    end
    case (op)
      OPC_MUL: aluOp = ALU_MUL;
      OPC_DIV: aluOp = ALU_DIV;
      OPC_DA: aluOp = ALU_DA;
      default: ;
    endcase
    if (aluOp == ALU_MUL || aluOp == ALU_DIV) begin
      aluB = b;
    end
  end

  aid_alu u_alu (
    .aluOp(aluOp),
    .opA(aluA),
    .opB(aluB),
    .cyIn(program_status_word[PSW_CY]),
    .acIn(program_status_word[PSW_AC]),
    .res(aluRes),
    .resHi(aluHi),
    .cyOut(aluCy),
    .acOut(aluAc),
    .ovOut(aluOv)
  );

  // Program memory address: table lookups borrow the bus in the last cycle
  always_comb begin
    codeAddr = pc;
    if (last && op == OPC_TBL_DP) begin
      codeAddr = {dph, dpl} + {8'h00, acc};
    end else if (last && op == OPC_TBL_PC) begin
      codeAddr = pc + {8'h00, acc};
    end
  end

  // Sequencing: one byte per cycle until length, then padding to cycle count
  always_comb begin
    next_state = state;
    next_step = step + 3'h1;
    next_pc = pc;
    next_opReg = opReg;
    next_byte1 = byte1;
    if (state == ST_FETCH) begin
      next_opReg = codeData;
    end
    if (step == 3'h1) begin
      next_byte1 = codeData;
    end
    if (step < len) begin
      next_pc = pc + 16'h0001;
    end
    if (last) begin
      next_step = 3'h0;
      next_state = ST_FETCH;
    end else if (step + 3'h1 < len) begin
      next_state = ST_BYTES;
    end else begin
      next_state = ST_WAIT;
    end
  end

  // Execute in the last cycle of each instruction
  always_comb begin
    next_acc = acc;
    next_b = b;
    next_psw = program_status_word;
    next_sp = sp;
    next_dpl = dpl;
    next_dph = dph;
    wrEn = 1'b0;
    wrAddr = ADDR_ACC;
    wrData = aluRes;
    auxRdEn = 1'b0;
    auxWrEn = 1'b0;
    // 8-bit pointer register or 16-bit data pointer
    auxAddr = op[1] ? {8'h00, riVal} : {dph, dpl};
    auxWrData = acc;
    if (last) begin
      // accumulator is both source and destination
      if (aluOp == ALU_ADD || aluOp == ALU_SUM_WITH_CARRY_OP || aluOp == ALU_DIFFERENCE_BORROW_OP) begin
        next_acc = aluRes;
        next_psw[PSW_CY] = aluCy;
        next_psw[PSW_AC] = aluAc;
        next_psw[PSW_OV] = aluOv;
      end else if (aluOp == ALU_INC || aluOp == ALU_DEC) begin
        // result lands in accumulator, register, direct or indirect location
        wrEn = 1'b1;
        wrAddr = (lo == LO_IMM) ? ADDR_ACC : rdAddr;
      end
      case (op)
        OPC_MUL, OPC_DIV: begin
          // accumulator and B as a pair
          next_acc = aluRes;
          next_b = aluHi;
          next_psw[PSW_CY] = 1'b0;
          next_psw[PSW_OV] = aluOv;
        end
        OPC_DA: begin
          next_acc = aluRes;
          next_psw[PSW_CY] = aluCy;
        end
        OPC_INC_DP: {next_dph, next_dpl} = {dph, dpl} + 16'h0001;
        OPC_CLR_C: next_psw[PSW_CY] = 1'b0;
        OPC_SET_C: next_psw[PSW_CY] = 1'b1;
        OPC_INV_C: next_psw[PSW_CY] = ~program_status_word[PSW_CY];
        OPC_RLC: {next_psw[PSW_CY], next_acc} = {acc, program_status_word[PSW_CY]};
        OPC_RRC: {next_acc, next_psw[PSW_CY]} = {program_status_word[PSW_CY], acc};
        OPC_CLR_BIT, OPC_SET_BIT, OPC_INV_BIT: begin
          // Read-modify-write of the holding byte
          wrEn = 1'b1;
          wrAddr = bitByte;
          wrData = rdByte;
          wrData[cur1[2:0]] = (op == OPC_SET_BIT) | ((op == OPC_INV_BIT) & ~bitVal);
        end
        OPC_MOV_DIR_IMM: begin
          wrEn = 1'b1;
          wrAddr = cur1;
          wrData = codeData;
        end
        OPC_MOV_A_DIR: next_acc = rdByte;
        OPC_MOV_A_IMM: next_acc = cur1;
        OPC_MOV_DIR_A: begin
          wrEn = 1'b1;
          wrAddr = cur1;
          wrData = acc;
        end
        OPC_MOV_DP: {next_dph, next_dpl} = {cur1, codeData};
        OPC_TBL_DP, OPC_TBL_PC: next_acc = codeData;
        OPC_XRD_DP, OPC_XRD_R0, OPC_XRD_R1: begin
          auxRdEn = 1'b1;
          next_acc = auxRdData;
        end
        OPC_XWR_DP, OPC_XWR_R0, OPC_XWR_R1: auxWrEn = 1'b1;
        OPC_PUSH: begin
          // push writes above the stack pointer
          next_sp = spInc;
          wrEn = 1'b1;
          wrAddr = {1'b0, spInc[6:0]};
          wrData = rdByte;
        end
        OPC_POP: begin
          next_sp = sp - 8'h01;
          wrEn = 1'b1;
          wrAddr = cur1;
          wrData = rdByte;
        end
        default: ;
      endcase
      // a write to the status word overrides computed flags
      if (wrEn) begin
        case (wrAddr)
          ADDR_ACC: next_acc = wrData;
          ADDR_B: next_b = wrData;
          ADDR_PSW: next_psw = wrData;
          ADDR_SP: next_sp = wrData;
          ADDR_DPL: next_dpl = wrData;
          ADDR_DPH: next_dph = wrData;
          default: ;
        endcase
      end
    end
  end

  // Core registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_FETCH;
      step <= 3'h0;
      pc <= PC_RESET;
      opReg <= BYTE_ZERO;
      byte1 <= BYTE_ZERO;
      acc <= BYTE_ZERO;
      b <= BYTE_ZERO;
      program_status_word <= BYTE_ZERO;
      sp <= SP_RESET;
      dpl <= BYTE_ZERO;
      dph <= BYTE_ZERO;
    end else begin
      state <= next_state;
      step <= next_step;
      pc <= next_pc;
      opReg <= next_opReg;
      byte1 <= next_byte1;
      acc <= next_acc;
      b <= next_b;
      program_status_word <= next_psw;
      sp <= next_sp;
      dpl <= next_dpl;
      dph <= next_dph;
    end
  end

  // Internal RAM; no reset, contents are undefined after power-up
  always_ff @(posedge clk_sys) begin
    if (!rst && wrEn && !wrAddr[7]) begin
      iram[wrAddr[6:0]] <= wrData;
    end
  end

  assign accOut = acc;
  assign statusOut = program_status_word;
  assign pcOut = pc;

endmodule

// ==== verif/aid_mem_model.sv ====
`timescale 1ns/1ps
// Program memory and aux RAM, both answering in the same cycle
module aid_mem_model (
  // Clock
  input wire logic clk_sys,
  // Program memory
  input wire logic [15:0] codeAddr,
  output logic [7:0] codeData,
  // Aux RAM
  input wire logic [15:0] auxAddr,
  input wire logic [7:0] auxWrData,
  input wire logic auxWrEn,
  input wire logic auxRdEn,
  output logic [7:0] auxRdData
);
  logic [7:0] code [0:65535];
  logic [7:0] aux [0:65535];
  logic [7:0] junk = 8'h5A;
  assign codeData = code[codeAddr];
  // Idle read bus moves every cycle, so stale data never passes
  assign auxRdData = auxRdEn ? aux[auxAddr] : junk;
  always @(posedge clk_sys) begin
    junk <= ~junk + 8'h01;
    if (auxWrEn) begin
      aux[auxAddr] <= auxWrData;
    end
  end
endmodule

// ==== verif/aid_core_assertions.sv ====
`timescale 1ns/1ps
module aid_core_chk
  import aid_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Program memory
  input wire logic [15:0] codeAddr,
  input wire logic [7:0] codeData,
  // Aux RAM
  input wire logic [15:0] auxAddr,
  input wire logic [7:0] auxWrData,
  input wire logic auxWrEn,
  input wire logic auxRdEn,
  input wire logic [7:0] auxRdData,
  // Observation
  input wire logic [7:0] accOut,
  input wire logic [7:0] statusOut,
  input wire logic [15:0] pcOut,
  input wire logic instrDone
);
  logic fetchCyc;
  logic [7:0] curOp;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Opcode cycle follows reset or a finished instruction
  always_ff @(posedge clk_sys) begin
    fetchCyc <= rst | instrDone;
    if (fetchCyc) begin
      curOp <= codeData;
    end
  end
  reset_clears_a: assert property (
    disable iff (1'b0) rst |=> accOut == 8'h00 && pcOut == 16'h0000 && statusOut == 8'h00)
    else $error("state not cleared by reset");
  first_fetch_a: assert property ($fell(rst) |-> codeAddr == 16'h0000)
    else $error("first fetch not at zero");
  single_cycle_a: assert property (fetchCyc && (codeData[7:3] inside {5'h05, 5'h07, 5'h13}
    || codeData[7:1] inside {7'h13, 7'h1B, 7'h4B}) |-> instrDone)
    else $error("register or indirect form not one cycle");
  two_cycle_a: assert property (fetchCyc && codeData inside {8'h24, 8'h25, 8'h34, 8'h35,
    8'h94, 8'h95} |-> !instrDone ##1 instrDone ##1 pcOut == $past(pcOut, 2) + 16'h0002)
    else $error("two byte arithmetic timing wrong");
  add_imm_sum_a: assert property (!fetchCyc && instrDone && curOp == 8'h24
    |=> {statusOut[7], accOut} == {1'b0, $past(accOut)} + {1'b0, $past(codeData)})
    else $error("immediate add result wrong");
  difference_borrow_op_imm_a: assert property (!fetchCyc && instrDone && curOp == 8'h94
    |=> {statusOut[7], accOut} == {1'b0, $past(accOut)} - {1'b0, $past(codeData)}
    - ($past(statusOut) >= 8'h80))
    else $error("immediate subtract result wrong");
  mul_div_a: assert property (fetchCyc && (codeData == 8'hA4 || codeData == 8'h84)
    |-> (!instrDone) [*4] ##1 instrDone ##1 !statusOut[7])
    else $error("multiply or divide timing or carry wrong");
  carry_force_a: assert property (fetchCyc && codeData inside {8'hC3, 8'hD3}
    |=> statusOut[7] == (($past(codeData) & 8'h10) != 8'h00))
    else $error("carry set or clear wrong");
  rotate_carry_a: assert property (fetchCyc && codeData == 8'h33
    |=> {statusOut[7], accOut} == ({$past(accOut), 1'b0} | ($past(statusOut) >= 8'h80)))
    else $error("left rotate through carry wrong");
  aux_write_a: assert property (auxWrEn |-> instrDone && !fetchCyc
    && auxWrData == accOut && curOp inside {8'hF0, 8'hF2, 8'hF3})
    else $error("aux write outside its cycle");
  aux_read_a: assert property (auxRdEn |=> accOut == $past(auxRdData))
    else $error("aux read data not loaded");
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import aid_pkg::*;
;
  typedef struct {logic [7:0] acc; logic [2:0] fl; logic [15:0] pc; int cyc;} aid_note_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] codeAddr, auxAddr, pcOut, wp, x;
  logic [7:0] codeData, auxWrData, auxRdData, accOut, statusOut, mAcc, a, b, op, ob;
  logic auxWrEn, auxRdEn, instrDone, pend, c;
  logic [2:0] mF;
  logic [31:0] seed = 32'h155879DB;
  logic [3:0] rows [3] = '{4'h2, 4'h3, 4'h9};
  logic [7:0] cops [5] = '{8'hC3, 8'hD3, 8'hB3, 8'h33, 8'h13};
  aid_note_t nq[$];
  aid_note_t n;
  int errTotal = 0, compares = 0, cnt = 0, lastCyc = 0, cycles = 0, ln;
  aid_core DUT (.clk_sys, .rst, .codeAddr, .codeData, .auxAddr, .auxWrData, .auxWrEn,
    .auxRdEn, .auxRdData, .accOut, .statusOut, .pcOut, .instrDone);
  aid_mem_model mem (.clk_sys, .codeAddr, .codeData, .auxAddr, .auxWrData, .auxWrEn,
    .auxRdEn, .auxRdData);
  always #2.5 clk_sys = ~clk_sys;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Returns carry, aux carry, overflow and result
  function automatic logic [10:0] arith(input logic [3:0] r, input logic [7:0] p, q,
      input logic cin);
    logic ci;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    ci = (r == 4'h2) ? 1'b0 : cin;
    if (r == 4'h9) begin
      s = {1'b0, p} - {1'b0, q} - ci;
      h = {1'b0, p[3:0]} - {1'b0, q[3:0]} - ci;
      l = {1'b0, p[6:0]} - {1'b0, q[6:0]} - ci;
    end else begin
      s = {1'b0, p} + {1'b0, q} + ci;
      h = {1'b0, p[3:0]} + {1'b0, q[3:0]} + ci;
      l = {1'b0, p[6:0]} + {1'b0, q[6:0]} + ci;
    end
    return {s[8], h[4], s[8] ^ l[7], s[7:0]};
  endfunction
  task automatic cmp(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Load one instruction and note what must follow it
  task automatic put(input int len, cyc, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00);
    mem.code[wp] = b0;
    mem.code[wp + 16'h1] = b1;
    mem.code[wp + 16'h2] = b2;
    wp += len[15:0];
    nq.push_back('{mAcc, mF, wp, cyc});
  endtask
  task automatic start();
    @(posedge clk_sys);
    #1 rst = 1'b1;
    nq.delete();
    for (int i = 0; i < 512; i++) mem.code[i] = 8'h00;
    wp = 16'h0000;
    mAcc = 8'h00;
    mF = 3'h0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic go(input string name);
    int w;
    w = 0;
    @(posedge clk_sys);
    #1 rst = 1'b0;
    while (nq.size() > 0 && w < 500) begin
      @(posedge clk_sys);
      w++;
    end
    cmp(nq.size(), 0);
    $display("test %s done", name);
  endtask
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Result checks one cycle after each finished instruction
  always @(negedge clk_sys) begin
    if (rst) begin
      pend = 1'b0;
      cnt = 0;
    end else begin
      cnt++;
      if (pend && nq.size() > 0) begin
        n = nq.pop_front();
        cmp(accOut, n.acc);
        cmp({statusOut[7:6], statusOut[2]}, n.fl);
        cmp(pcOut, n.pc);
        cmp(lastCyc, n.cyc);
      end
      pend = instrDone;
      if (instrDone === 1'b1) begin
        lastCyc = cnt;
        cnt = 0;
      end
    end
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      summarize();
    end
  end
  initial begin
    // every operand form of the three arithmetic rows
    start();
    for (int k = 0; k < 24; k++) begin
      a = rnd();
      b = rnd();
      c = rnd() > 8'h7F;
      mAcc = a;
      put(2, 2, 8'h74, a);
      mF[2] = c;
      put(1, 1, c ? 8'hD3 : 8'hC3);
      case (k % 4)
        0: begin op = {rows[(k / 4) % 3], 4'h4}; ob = b; ln = 2; end
        1: begin put(3, 3, 8'h75, 8'h40, b); op = {rows[(k / 4) % 3], 4'h5}; ob = 8'h40; ln = 2; end
        2: begin put(3, 3, 8'h75, {5'h00, k[2:0]}, b); op = {rows[(k / 4) % 3], 1'b1, k[2:0]};
          ln = 1; end
        default: begin put(3, 3, 8'h75, {7'h00, k[2]}, 8'h41); put(3, 3, 8'h75, 8'h41, b);
          op = {rows[(k / 4) % 3], 3'b011, k[2]}; ln = 1; end
      endcase
      {mF, mAcc} = arith(rows[(k / 4) % 3], mAcc, b, mF[2]);
      put(ln, ln, op, ob);
    end
    go("arith");
    start();
    for (int k = 0; k < 10; k++) begin
      a = rnd();
      mAcc = a;
      put(2, 2, 8'h74, a);
      case (k % 5)
        0: mF[2] = 1'b0;
        1: mF[2] = 1'b1;
        2: mF[2] = ~mF[2];
        3: {mF[2], mAcc} = {mAcc, mF[2]};
        default: {mAcc, mF[2]} = {mF[2], mAcc};
      endcase
      put(1, 1, cops[k % 5]);
    end
    go("carry");
    // multiply, divide, divide by zero and length decoding
    start();
    a = rnd();
    b = rnd();
    put(3, 3, 8'h75, ADDR_B, b);
    mAcc = a;
    put(2, 2, 8'h74, a);
    x = a * b;
    mAcc = x[7:0];
    mF[2] = 1'b0;
    mF[0] = x[15:8] != 8'h00;
    put(1, 5, 8'hA4);
    b = rnd() | 8'h01;
    put(3, 3, 8'h75, ADDR_B, b);
    mAcc = rnd();
    put(2, 2, 8'h74, mAcc);
    mAcc = mAcc / b;
    mF[0] = 1'b0;
    put(1, 5, 8'h84);
    put(3, 3, 8'h75, ADDR_B, 8'h00);
    mF[0] = 1'b1;
    put(1, 5, 8'h84);
    put(1, 3, 8'hA3);
    put(1, 1, 8'h00);
    put(1, 1, 8'hA5);
    put(3, 3, 8'h43, 8'h50, 8'h00);
    x = wp + 16'h0003;
    put(3, 3, 8'h02, x[15:8], x[7:0]);
    // Decimal adjust of both digits, then decrement, push, pop and direct read
    mAcc = 8'hAB;
    put(2, 2, 8'h74, 8'hAB);
    {mF[2], mAcc} = 9'h111;
    put(1, 1, 8'hD4);
    mAcc = 8'h10;
    put(1, 1, 8'h14);
    put(2, 2, 8'hC0, ADDR_ACC);
    mAcc = 8'h00;
    put(2, 2, 8'h74, 8'h00);
    put(2, 2, 8'hD0, ADDR_B);
    mAcc = 8'h10;
    put(2, 2, 8'hE5, ADDR_B);
    go("muldiv");
    // status word writes and bank selection
    start();
    b = rnd();
    mF = 3'b111;
    put(3, 3, 8'h75, ADDR_PSW, 8'hC4);
    put(3, 3, 8'h75, 8'h0B, b);
    put(3, 3, 8'h75, 8'h03, ~b);
    mF = 3'b000;
    put(3, 3, 8'h75, ADDR_PSW, 8'h08);
    mAcc = rnd();
    put(2, 2, 8'h74, mAcc);
    {mF, mAcc} = arith(4'h2, mAcc, b, 1'b0);
    put(1, 1, 8'h2B);
    mF[2] = 1'b1;
    put(2, 2, 8'hD2, 8'hD7);
    mF[0] = ~mF[0];
    put(2, 2, 8'hB2, 8'hD2);
    mF[1] = 1'b0;
    put(2, 2, 8'hC2, 8'hD6);
    go("status");
    // aux RAM through every pointer, then both table reads
    start();
    a = rnd();
    put(3, 3, 8'h90, 8'h12, 8'h34);
    mAcc = a;
    put(2, 2, 8'h74, a);
    put(1, 2, 8'hF0);
    mAcc = 8'h00;
    put(2, 2, 8'h74, 8'h00);
    mAcc = a;
    put(1, 2, 8'hE0);
    for (int p = 0; p < 2; p++) begin
      b = rnd();
      put(3, 3, 8'h75, p[7:0], 8'h56 + p[7:0]);
      mAcc = b;
      put(2, 2, 8'h74, b);
      put(1, 2, 8'hF2 | p[7:0]);
      mAcc = 8'h00;
      put(2, 2, 8'h74, 8'h00);
      mAcc = b;
      put(1, 2, 8'hE2 | p[7:0]);
    end
    mem.code[16'h1237] = rnd();
    mAcc = 8'h03;
    put(2, 2, 8'h74, 8'h03);
    mAcc = mem.code[16'h1237];
    put(1, 3, 8'h93);
    mAcc = 8'h01;
    put(2, 2, 8'h74, 8'h01);
    mAcc = 8'h04;
    put(1, 3, 8'h83);
    put(1, 1, 8'h00);
    mAcc = 8'h05;
    put(1, 1, 8'h04);
    go("aux");
    cmp(mem.aux[16'h1234], a);
    summarize();
  end
endmodule
bind aid_core aid_core_chk chk (.clk_sys, .rst, .codeAddr, .codeData, .auxAddr, .auxWrData,
  .auxWrEn, .auxRdEn, .auxRdData, .accOut, .statusOut, .pcOut, .instrDone);
